// ---- ask_level_defines.svh ----
`ifndef ASK_LEVEL_DEFINES_SVH
`define ASK_LEVEL_DEFINES_SVH

// Sample stream and reference synthesis
`define SAMP_W 12
`define SAMPLE_PERIOD_PS 5000
`define REF_DIV 46
`define PHASE_W 6
`define REF_FRAC 13
`define REF_PEAK 16384.0
`define PROD_W 16

// First (one period) and last (10 us) averaging windows
`define SUM1_W 24
`define AVG_TIME_NS 10000
`define AVG_LEN (`AVG_TIME_NS * 1000 / `SAMPLE_PERIOD_PS)
`define PTR2K_W 11
`define SUM2_W 28

// Magnitude, square root and RMS scaling
`define MAG_W 33
`define RAD_W 34
`define ROOT_W 17
`define REM_W 19
`define ROOT_STEPS 17
`define RMS_SCALE 17'd46341
`define RMS_SHIFT 16
`define LEVEL_W 16
`define CNT_W 16

`endif

// ---- ask_level_pkg.sv ----
`include "ask_level_defines.svh"

package ask_level_pkg;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_MIX  = 9'h002,
    ST_SUM  = 9'h004,
    ST_SQ   = 9'h008,
    ST_ROOT = 9'h010,
    ST_RMS  = 9'h020,
    ST_AVG  = 9'h040,
    ST_CMP  = 9'h080,
    ST_FIN  = 9'h100
  } state_t;

  typedef struct packed {
    logic first;
    logic last;
    logic signed [`SAMP_W-1:0] data;
  } samp_word_t;

endpackage

// ---- delay_ram_if.sv ----
`timescale 1ns/10ps

interface delay_ram_if #(parameter int AW = 6, parameter int DW = 32);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport user (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ---- delay_ram.sv ----
`timescale 1ns/10ps

module delay_ram #(
  parameter int DEPTH = 46,
  parameter int AW = 6,
  parameter int DW = 32
) (
  // Clock
  input wire logic clk,
  // Port
  delay_ram_if.mem ram
);

  logic [DW-1:0] mem_array [DEPTH];

  // Read-first: a read at the written address returns the word being replaced
  always_ff @(posedge clk) begin
    if (ram.we) begin
      mem_array[ram.addr] <= ram.wdata;
    end
    ram.rdata <= mem_array[ram.addr];
  end

endmodule

// ---- ask_uplink_level_meter.sv ----
// Contract
// [RL1] Mix input with quadrature sine and cosine references near 4.35 MHz.
// [RL2] Samples arrive at 200 Msps; a capture covers at least one zero bit.
// [RL3] Source starts delivering at least 200 ns before the bit begins.
// [RL4] Reference is sample rate over 46: 46 samples per period.
// [RL5] Multiply each sample by sine and cosine of peak 2, one product each.
// [RL6] Sliding 46-sample sum divided by 46; first 45 outputs invalid.
// [RL7] Square both averaged branches and add them sample by sample.
// [RL8] Square root of each sum, divided by root two for RMS.
// [RL9] Average RMS stream over 10 us: 2000-sample sliding sum over 2000.
// [RL10] Reported level is the largest 2000-sample average within the capture.
// [RL11] On-line, a found window position may be held for later bits.
// [RL12] References from 46-entry table, modulo-46 counter cleared at capture start.
// [RL13] One-cycle result-valid strobe with the maximum once capture is processed.
`timescale 1ns/10ps
`include "ask_level_defines.svh"

module ask_uplink_level_meter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample stream
  input wire logic samp_valid,
  input wire logic signed [`SAMP_W-1:0] samp_data,
  input wire logic samp_first,
  input wire logic samp_last,
  output logic samp_ready,
  // Control
  input wire logic hold_pos,
  // Result
  output logic level_valid,
  output logic [`LEVEL_W-1:0] level,
  output logic [`CNT_W-1:0] level_pos
);

  function automatic logic [31:0] square(input logic signed [15:0] v);
    square = 32'(v) * 32'(v);
  endfunction

  ask_level_pkg::state_t state_reg, state_next;

  // Two-entry input buffer; the datapath takes several cycles per sample, so
  // the source is stalled through samp_ready rather than losing words
  ask_level_pkg::samp_word_t buf_reg [2];
  ask_level_pkg::samp_word_t word_reg;
  logic [1:0] buf_cnt_reg;
  logic samp_ready_reg;
  wire push = samp_valid & samp_ready_reg; // see [RL2]
  wire pop = (state_reg == ask_level_pkg::ST_IDLE) & (buf_cnt_reg != 2'd0);
  wire [1:0] buf_cnt_next = buf_cnt_reg + {1'b0, push} - {1'b0, pop};
  wire push_to_head = push & ((buf_cnt_reg == 2'd0) | ((buf_cnt_reg == 2'd1) & pop));
  wire ask_level_pkg::samp_word_t in_word = '{samp_first, samp_last, samp_data};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
      buf_cnt_reg <= 2'd0;
      samp_ready_reg <= 1'b0;
    end else begin
      if (pop) begin
        buf_reg[0] <= buf_reg[1];
      end
      if (push_to_head) begin
        buf_reg[0] <= in_word;
      end else if (push) begin
        buf_reg[1] <= in_word;
      end
      buf_cnt_reg <= buf_cnt_next;
      samp_ready_reg <= (buf_cnt_next != 2'd2);
    end
  end

  // Reference tables, built as constants at elaboration
  localparam real TWO_PI = 6.283185307179586;
  logic signed [15:0] sin_lut [`REF_DIV];
  logic signed [15:0] cos_lut [`REF_DIV];
  for (genvar k = 0; k < `REF_DIV; k++) begin : g_lut
    assign sin_lut[k] = 16'($rtoi(`REF_PEAK * $sin(TWO_PI * k / `REF_DIV))); // see [RL5]
    assign cos_lut[k] = 16'($rtoi(`REF_PEAK * $cos(TWO_PI * k / `REF_DIV))); // see [RL1]
  end

  // Mixer
  logic [`PHASE_W-1:0] phase_reg;
  wire signed [27:0] mul_i = word_reg.data * cos_lut[phase_reg]; // see [RL4]
  wire signed [27:0] mul_q = word_reg.data * sin_lut[phase_reg];
  wire signed [`PROD_W-1:0] prod_i = mul_i[`REF_FRAC +: `PROD_W];
  wire signed [`PROD_W-1:0] prod_q = mul_q[`REF_FRAC +: `PROD_W];

  // One-period sliding sums; delay line indexed by the phase counter itself
  delay_ram_if #(.AW(`PHASE_W), .DW(2 * `PROD_W)) ram46 ();
  delay_ram #(.DEPTH(`REF_DIV), .AW(`PHASE_W), .DW(2 * `PROD_W)) u_ram46 (
    .clk(clk),
    .ram(ram46)
  );
  logic signed [`PROD_W-1:0] prod_i_reg, prod_q_reg;
  logic signed [`SUM1_W-1:0] sum_i_reg, sum_q_reg;
  logic [7:0] n_reg;
  wire full46 = (n_reg == 8'(`REF_DIV));
  wire valid46 = (n_reg >= 8'(`REF_DIV - 1));
  wire signed [`PROD_W-1:0] old_i = full46 ? $signed(ram46.rdata[2*`PROD_W-1 -: `PROD_W]) : '0;
  wire signed [`PROD_W-1:0] old_q = full46 ? $signed(ram46.rdata[`PROD_W-1:0]) : '0;
  wire signed [`SUM1_W-1:0] sum_i_next = sum_i_reg + `SUM1_W'(prod_i_reg) - `SUM1_W'(old_i);
  wire signed [`SUM1_W-1:0] sum_q_next = sum_q_reg + `SUM1_W'(prod_q_reg) - `SUM1_W'(old_q);
  wire signed [15:0] avg_i = 16'(sum_i_reg / $signed(`SUM1_W'(`REF_DIV))); // see [RL6]
  wire signed [15:0] avg_q = 16'(sum_q_reg / $signed(`SUM1_W'(`REF_DIV)));
  wire [`MAG_W-1:0] mag = {1'b0, square(avg_i)} + {1'b0, square(avg_q)}; // see [RL7]
  assign ram46.addr = phase_reg;
  assign ram46.we = (state_reg == ask_level_pkg::ST_SUM); // see [RL6]
  assign ram46.wdata = {prod_i_reg, prod_q_reg};

  // Restoring square root, two radicand bits per step
  logic [`RAD_W-1:0] rad_reg;
  logic [`REM_W-1:0] rem_reg;
  logic [`ROOT_W-1:0] root_reg;
  logic [4:0] step_reg;
  wire [`REM_W-1:0] rem_sh = {rem_reg[`REM_W-3:0], rad_reg[`RAD_W-1 -: 2]};
  wire [`REM_W-1:0] trial = {root_reg, 2'b01};
  wire fits = (rem_sh >= trial);
  wire [33:0] rms_mul = root_reg * `RMS_SCALE;
  wire root_done = (step_reg == 5'(`ROOT_STEPS - 1));

  // 10 us sliding average over the RMS stream
  delay_ram_if #(.AW(`PTR2K_W), .DW(`LEVEL_W)) ram2k ();
  delay_ram #(.DEPTH(`AVG_LEN), .AW(`PTR2K_W), .DW(`LEVEL_W)) u_ram2k (
    .clk(clk),
    .ram(ram2k)
  );
  logic [`LEVEL_W-1:0] rms_reg, best_reg, level_reg;
  logic [`PTR2K_W-1:0] ptr2k_reg;
  logic [`SUM2_W-1:0] sum2k_reg;
  logic [`CNT_W-1:0] m_reg, best_pos_reg, hold_pos_reg, level_pos_reg;
  logic pos_known_reg, level_valid_reg;
  wire full2k = (m_reg >= `CNT_W'(`AVG_LEN));
  wire [`LEVEL_W-1:0] old_rms = full2k ? ram2k.rdata : '0;
  wire [`SUM2_W-1:0] sum2k_next = sum2k_reg + `SUM2_W'(rms_reg) - `SUM2_W'(old_rms);
  wire [`LEVEL_W-1:0] avg2k = `LEVEL_W'(sum2k_reg / `SUM2_W'(`AVG_LEN)); // see [RL9]
  wire holding = hold_pos & pos_known_reg;
  assign ram2k.addr = ptr2k_reg;
  assign ram2k.we = (state_reg == ask_level_pkg::ST_AVG); // see [RL9]
  assign ram2k.wdata = rms_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ask_level_pkg::ST_IDLE: if (pop) state_next = ask_level_pkg::ST_MIX;
      ask_level_pkg::ST_MIX: state_next = ask_level_pkg::ST_SUM;
      ask_level_pkg::ST_SUM: begin
        state_next = valid46 ? ask_level_pkg::ST_SQ : ask_level_pkg::ST_FIN; // see [RL6]
      end
      ask_level_pkg::ST_SQ: state_next = ask_level_pkg::ST_ROOT;
      ask_level_pkg::ST_ROOT: if (root_done) state_next = ask_level_pkg::ST_RMS;
      ask_level_pkg::ST_RMS: state_next = ask_level_pkg::ST_AVG;
      ask_level_pkg::ST_AVG: state_next = ask_level_pkg::ST_CMP;
      ask_level_pkg::ST_CMP: state_next = ask_level_pkg::ST_FIN;
      ask_level_pkg::ST_FIN: state_next = ask_level_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ask_level_pkg::ST_IDLE;
      word_reg <= '0;
      phase_reg <= '0;
      n_reg <= '0;
      prod_i_reg <= '0;
      prod_q_reg <= '0;
      sum_i_reg <= '0;
      sum_q_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (pop) begin
        word_reg <= buf_reg[0];
      end
      if (pop & buf_reg[0].first) begin
        phase_reg <= '0; // see [RL12]
        n_reg <= '0;
        sum_i_reg <= '0;
        sum_q_reg <= '0;
      end
      if (state_reg == ask_level_pkg::ST_MIX) begin
        prod_i_reg <= prod_i;
        prod_q_reg <= prod_q;
      end
      if (state_reg == ask_level_pkg::ST_SUM) begin
        sum_i_reg <= sum_i_next;
        sum_q_reg <= sum_q_next;
        phase_reg <= (phase_reg == `PHASE_W'(`REF_DIV - 1)) ? '0 : phase_reg + 1'b1; // see [RL12]
        n_reg <= full46 ? n_reg : n_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rad_reg <= '0;
      rem_reg <= '0;
      root_reg <= '0;
      step_reg <= '0;
      rms_reg <= '0;
    end else if (state_reg == ask_level_pkg::ST_SQ) begin
      rad_reg <= {1'b0, mag};
      rem_reg <= '0;
      root_reg <= '0;
      step_reg <= '0;
    end else if (state_reg == ask_level_pkg::ST_ROOT) begin
      rem_reg <= fits ? rem_sh - trial : rem_sh; // see [RL8]
      root_reg <= {root_reg[`ROOT_W-2:0], fits};
      rad_reg <= {rad_reg[`RAD_W-3:0], 2'b00};
      step_reg <= step_reg + 1'b1;
    end else if (state_reg == ask_level_pkg::ST_RMS) begin
      rms_reg <= rms_mul[`RMS_SHIFT +: `LEVEL_W]; // see [RL8]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr2k_reg <= '0;
      sum2k_reg <= '0;
      m_reg <= '0;
      best_reg <= '0;
      best_pos_reg <= '0;
    end else if (pop & buf_reg[0].first) begin
      ptr2k_reg <= '0;
      sum2k_reg <= '0;
      m_reg <= '0;
      best_reg <= '0;
      best_pos_reg <= '0;
    end else if (state_reg == ask_level_pkg::ST_AVG) begin
      sum2k_reg <= sum2k_next;
      ptr2k_reg <= (ptr2k_reg == `PTR2K_W'(`AVG_LEN - 1)) ? '0 : ptr2k_reg + 1'b1;
      m_reg <= (m_reg == '1) ? m_reg : m_reg + 1'b1;
    end else if ((state_reg == ask_level_pkg::ST_CMP) && full2k) begin
      if (holding) begin
        if (m_reg == hold_pos_reg) begin
          best_reg <= avg2k; // see [RL11]
          best_pos_reg <= m_reg;
        end
      end else if (avg2k > best_reg) begin
        best_reg <= avg2k; // see [RL10]
        best_pos_reg <= m_reg;
      end
    end
  end

  // Result; a capture too short to fill a 10 us window reports level zero
  wire report = (state_reg == ask_level_pkg::ST_FIN) & word_reg.last;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_valid_reg <= 1'b0;
      level_reg <= '0;
      level_pos_reg <= '0;
      hold_pos_reg <= '0;
      pos_known_reg <= 1'b0;
    end else begin
      level_valid_reg <= report; // see [RL13]
      if (report) begin
        level_reg <= best_reg;
        level_pos_reg <= best_pos_reg;
        if (!holding && full2k) begin
          hold_pos_reg <= best_pos_reg; // see [RL11]
          pos_known_reg <= 1'b1;
        end
      end
    end
  end

  assign samp_ready = samp_ready_reg;
  assign level_valid = level_valid_reg;
  assign level = level_reg;
  assign level_pos = level_pos_reg;

endmodule

// ---- ask_level_chk.sv ----
`timescale 1ns/10ps
`include "ask_level_defines.svh"
module ask_level_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stream and result
  input wire logic samp_valid,
  input wire logic samp_first,
  input wire logic samp_last,
  input wire logic samp_ready,
  input wire logic hold_pos,
  input wire logic level_valid,
  input wire logic [`LEVEL_W-1:0] level,
  input wire logic [`CNT_W-1:0] level_pos
);
  logic take, pend_reg, pend_next;
  logic [15:0] cnt_reg, cnt_next, len_reg;
  assign take = samp_valid && samp_ready;
  assign cnt_next = samp_first ? 16'h1 : cnt_reg + 16'h1;
  assign pend_next = (take && samp_last) || (pend_reg && !level_valid);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      cnt_reg <= 16'h0;
      len_reg <= 16'h0;
    end else begin
      pend_reg <= pend_next;
      if (take) cnt_reg <= cnt_next;
      if (take && samp_last) len_reg <= cnt_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pulse_single: assert property (level_valid |=> !level_valid)
    else $error("result strobe longer than one cycle");
  a_level_holds: assert property (!level_valid |-> $stable(level) && $stable(level_pos))
    else $error("result changed without strobe");
  a_pulse_cause: assert property (level_valid |-> pend_reg)
    else $error("strobe without a finished capture");
  a_pulse_bound: assert property (take && samp_last |-> ##[1:300] level_valid)
    else $error("no result after last sample");
  a_short_empty: assert property (level_valid && len_reg < `AVG_LEN + 45 |->
    level == 0 && level_pos == 0) else $error("short capture gave a level");
  a_pos_range: assert property (level_valid && !hold_pos && len_reg >= `AVG_LEN + 45 |->
    level_pos >= `AVG_LEN && level_pos <= len_reg - 45) else $error("window index out of range");
  a_ready_wakes: assert property ($rose(rst_n) |-> !samp_ready ##1 samp_ready)
    else $error("ready not raised after reset");
  a_ready_bounded: assert property (!samp_ready |-> ##[1:120] samp_ready)
    else $error("input stalled too long");
  a_level_ceiling: assert property (level_valid |-> level <= 16'h0801)
    else $error("level above full scale");
endmodule

bind ask_uplink_level_meter ask_level_chk chk (.clk, .rst_n, .samp_valid, .samp_first,
  .samp_last, .samp_ready, .hold_pos, .level_valid, .level, .level_pos);

// ---- adc_source.sv ----
`timescale 1ns/10ps
`include "ask_level_defines.svh"
module adc_source (
  // Clock and handshake
  input wire logic clk,
  input wire logic samp_ready,
  // Sample stream
  output logic samp_valid,
  output logic signed [`SAMP_W-1:0] samp_data,
  output logic samp_first,
  output logic samp_last,
  // Status
  output logic stuck
);
  initial begin
    samp_valid = 1'b0;
    samp_data = 12'h5a5;
    samp_first = 1'b0;
    samp_last = 1'b0;
    stuck = 1'b0;
  end
  // Tone at exactly fs/46, so every full window after the lead-in sees the same products
  task automatic send(input int n, input real amp, input int lead, input int gap);
    int w;
    logic rdy;
    for (int i = 0; i < n; i++) begin
      samp_valid = 1'b1;
      samp_data = (i < lead) ? 12'h0 : 12'($rtoi(amp * $cos(6.283185307 * i / 46.0)));
      samp_first = (i == 0);
      samp_last = (i == n - 1);
      w = 0;
      // Ready is read between edges, where it has settled for the coming edge
      do begin
        rdy = samp_ready;
        @(posedge clk);
        #1;
        w++;
      end while (rdy !== 1'b1 && w < 200);
      if (rdy !== 1'b1) stuck = 1'b1;
      if (gap > 0) begin
        samp_valid = 1'b0;
        samp_data = ~samp_data;
        repeat (gap) @(posedge clk);
        #1;
      end
    end
    samp_valid = 1'b0;
    samp_data = ~samp_data;
    samp_first = 1'b0;
    samp_last = 1'b0;
  endtask
endmodule

// ---- ask_uplink_level_meter_tb_top.sv ----
`timescale 1ns/10ps
`include "ask_level_defines.svh"
module ask_uplink_level_meter_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hold_pos = 1'b0;
  logic samp_valid, samp_first, samp_last, samp_ready, level_valid, stuck;
  logic signed [`SAMP_W-1:0] samp_data;
  logic [`LEVEL_W-1:0] level, held;
  logic [`CNT_W-1:0] level_pos;
  int err_count = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  ask_uplink_level_meter dut (.clk(clk), .rst_n(rst_n), .samp_valid(samp_valid),
    .samp_data(samp_data), .samp_first(samp_first), .samp_last(samp_last),
    .samp_ready(samp_ready), .hold_pos(hold_pos), .level_valid(level_valid),
    .level(level), .level_pos(level_pos));
  adc_source src (.clk(clk), .samp_ready(samp_ready), .samp_valid(samp_valid),
    .samp_data(samp_data), .samp_first(samp_first), .samp_last(samp_last), .stuck(stuck));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_result;
    int k;
    check("source stall", {31'h0, stuck}, 32'h0);
    for (k = 0; k < 400; k++) begin
      @(posedge clk);
      #1;
      if (level_valid === 1'b1) break;
    end
    check("result strobe", {31'h0, k < 400}, 32'h1);
    if (k == 400) tally_and_finish;
  endtask
  task automatic t_reset;
    repeat (12) @(posedge clk);
    #1;
    check("ready in reset", {31'h0, samp_ready}, 32'h0);
    check("level in reset", {16'h0, level}, 32'h0);
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("ready after reset", {31'h0, samp_ready}, 32'h1);
  endtask
  // Slow source with a silent lead-in; too short to fill the 10 us window
  task automatic t_short;
    src.send(100, 1000.0, 40, 2);
    wait_result;
    check("short level", {16'h0, level}, 32'h0);
    check("short position", {16'h0, level_pos}, 32'h0);
  endtask
  // Two equal windows: the earlier one must win, at RMS index 2000
  task automatic t_tone;
    src.send(`AVG_LEN + 46, 1000.0, 0, 0);
    wait_result;
    check("tone level near 707", {31'h0, level >= 703 && level <= 708}, 32'h1);
    check("best window end", {16'h0, level_pos}, `AVG_LEN);
    held = level;
    @(posedge clk);
    #1;
    check("strobe width", {31'h0, level_valid}, 32'h0);
    check("level held", {16'h0, level}, {16'h0, held});
  endtask
  task automatic t_hold;
    hold_pos = 1'b1;
    src.send(60, 1500.0, 0, 0);
    wait_result;
    check("held window too short", {16'h0, level}, 32'h0);
    hold_pos = 1'b0;
  endtask
  initial begin
    t_reset;
    t_short;
    t_tone;
    t_hold;
    tally_and_finish;
  end
endmodule
